// ### logic/time_engine_pkg.sv
package time_engine_pkg;

  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int WORD_W = 16;          // staging and control width
  localparam int ADDR_W = 5;           // serial-port register address width
  localparam int SEC_W = 48;           // seconds count width
  localparam int NS_W = 30;            // nanoseconds count width
  localparam int STAGE_N = 5;          // number of staging words
  localparam int TS_N = 3;             // number of timestamp fifos

  // ----------------------------------------
  // register addresses on the management port
  // ----------------------------------------
  localparam logic [4:0] ADDR_WORD1 = 5'h09;
  localparam logic [4:0] ADDR_WORD2 = 5'h0A;
  localparam logic [4:0] ADDR_WORD3 = 5'h0B;
  localparam logic [4:0] ADDR_WORD4 = 5'h0C;
  localparam logic [4:0] ADDR_WORD5 = 5'h0D;
  localparam logic [4:0] ADDR_CTRL = 5'h0E;

  // ----------------------------------------
  // access-control field layout
  // ----------------------------------------
  localparam int CTRL_RD_BIT = 15;     // read strobe
  localparam int CTRL_READ_SELECT_LO = 8;    // read-select, 3 bits
  localparam int CTRL_WR_BIT = 7;      // write strobe
  localparam int CTRL_WRITE_SELECT_LO = 0;    // write-select, 4 bits
  localparam int EDGE_BIT = 15;        // edge polarity in word five
  localparam logic [15:0] RESET_WORD = 16'h0000;

  // ----------------------------------------
  // read-select codes
  // ----------------------------------------
  localparam logic [2:0] RSEL_TIME = 3'h0;
  localparam logic [2:0] RSEL_TS1 = 3'h1;
  localparam logic [2:0] RSEL_TS2 = 3'h2;
  localparam logic [2:0] RSEL_TS3 = 3'h3;

  // ----------------------------------------
  // write-select codes
  // ----------------------------------------
  localparam logic [3:0] WSEL_TIME = 4'h0;
  localparam logic [3:0] WSEL_PERIOD = 4'h1;
  localparam logic [3:0] WSEL_ADJUST = 4'h2;
  localparam logic [3:0] WSEL_PULSE_GENERATOR_ONE = 4'h3;
  localparam logic [3:0] WSEL_PULSE_GENERATOR_TWO = 4'h4;
  localparam logic [3:0] WSEL_MPD = 4'h8;
  localparam logic [3:0] WSEL_CORR1 = 4'h9;
  localparam logic [3:0] WSEL_CORR2 = 4'hA;
  localparam logic [3:0] WSEL_CORR3 = 4'hB;

  // source select value that means packet stamping
  localparam logic [2:0] SRC_PACKETS = 3'h0;

endpackage : time_engine_pkg

// ### logic/read_path_if.sv
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------
// read path between source mux and core
// ----------------------------------------
interface read_path_if;
  logic [4:0][15:0] loadWord;  // words one..five to load
  logic loadOk;                // select code names a real source
  logic hdrLoad;               // header data registers also load
  logic [15:0] hdrOne;         // message type and identity
  logic [15:0] hdrTwo;         // sequence identifier

  modport source (output loadWord, output loadOk, output hdrLoad, output hdrOne, output hdrTwo);
  modport sink (input loadWord, input loadOk, input hdrLoad, input hdrOne, input hdrTwo);
endinterface : read_path_if

`default_nettype wire

// ### logic/staging_read_mux.sv
`timescale 1ns/10ps
`default_nettype none

module staging_read_mux (
  // select and stamper modes
  input wire logic [2:0] selCode,
  input wire logic [2:0] stamperTwoSourceSelect,
  input wire logic [2:0] stamperThreeSourceSelect,
  // current time
  input wire logic [47:0] curSeconds,
  input wire logic [29:0] curNanos,
  // fifo head entries, index 0 is timestamper one
  input wire logic [2:0][47:0] tsSeconds,
  input wire logic [2:0][29:0] tsNanos,
  input wire logic [2:0] tsEdge,
  input wire logic [2:0][3:0] tsMsgType,
  input wire logic [2:0][11:0] tsIdentity,
  input wire logic [2:0][15:0] tsSequence,
  // result toward the core
  read_path_if.source rp
);

  // ----------------------------------------
  // source selection
  // ----------------------------------------
  wire logic isTime = (selCode == time_engine_pkg::RSEL_TIME);
  wire logic isFifo = (selCode == time_engine_pkg::RSEL_TS1) ||
                      (selCode == time_engine_pkg::RSEL_TS2) ||
                      (selCode == time_engine_pkg::RSEL_TS3);
  // fifo index; only meaningful when isFifo
  // held at zero otherwise so the index never leaves the three entries
  wire logic [1:0] fifoIdx = isFifo ? selCode[1:0] - 2'h1 : 2'h0;
  wire logic [47:0] secPick = isTime ? curSeconds : tsSeconds[fifoIdx];
  wire logic [29:0] nsPick = isTime ? curNanos : tsNanos[fifoIdx];
  // time reads carry zeros above the nanoseconds, fifo reads the edge
  wire logic edgePick = isFifo & tsEdge[fifoIdx];

  assign rp.loadWord[0] = secPick[15:0];
  assign rp.loadWord[1] = secPick[31:16];
  assign rp.loadWord[2] = secPick[47:32];
  assign rp.loadWord[3] = nsPick[15:0];
  assign rp.loadWord[4] = {edgePick, 1'b0, nsPick[29:16]};
  assign rp.loadOk = isTime | isFifo;

  assign rp.hdrLoad =
    ((selCode == time_engine_pkg::RSEL_TS3) &&
     (stamperThreeSourceSelect == time_engine_pkg::SRC_PACKETS)) ||
    ((selCode == time_engine_pkg::RSEL_TS2) &&
     (stamperTwoSourceSelect == time_engine_pkg::SRC_PACKETS));
  assign rp.hdrOne = {tsMsgType[fifoIdx], tsIdentity[fifoIdx]};
  assign rp.hdrTwo = tsSequence[fifoIdx];

endmodule : staging_read_mux

`default_nettype wire

// ### logic/time_engine_indirect_access.sv
// Contract
// - write strobe copies staging to destination
// - staging words hold last written value
// - read strobe loads staging from source
// - both strobes: write first, then read
// - read strobe bit 15, select 10:8
// - write strobe bit 7, select 3:0
// - stamper three pop updates both headers (code: only when stamperThreeSourceSelect is SRC_PACKETS)
// - stamper two pop updates both headers (code: only when stamperTwoSourceSelect is SRC_PACKETS)
// - word five bit 15 gives edge
// - time read layout in staging words
// - fifo pops, edge flag, zero bit
// - time write layout from staging words
// - period and time adjustment layouts
// - pulse generator command push layout
// - mean path delay and correction layouts
// - six sixteen-bit registers, zero reset, addresses
// - header one: message type, identity
// - header two: sequence identifier
`timescale 1ns/10ps
`default_nettype none

module time_engine_indirect_access (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // management register port
  input wire logic regWe,
  input wire logic regRe,
  input wire logic [4:0] regAddr,
  input wire logic [15:0] regWdata,
  output logic [15:0] regRdata,
  // stamper source configuration
  input wire logic [2:0] stamperTwoSourceSelect,
  input wire logic [2:0] stamperThreeSourceSelect,
  // current time from the engine
  input wire logic [47:0] curSeconds,
  input wire logic [29:0] curNanos,
  // timestamp fifo heads and pops
  input wire logic [2:0][47:0] tsSeconds,
  input wire logic [2:0][29:0] tsNanos,
  input wire logic [2:0] tsEdge,
  input wire logic [2:0][3:0] tsMsgType,
  input wire logic [2:0][11:0] tsIdentity,
  input wire logic [2:0][15:0] tsSequence,
  output logic [2:0] tsPop,
  // header data registers
  output logic [15:0] headerDataOne,
  output logic [15:0] headerDataTwo,
  // time load
  output logic timeLoadStb,
  output logic [47:0] timeLoadSeconds,
  output logic [29:0] timeLoadNanos,
  // period load
  output logic periodStb,
  output logic [7:0] periodNanos,
  output logic [31:0] periodFraction,
  // time adjustment
  output logic adjustStb,
  output logic [7:0] adjustNanos,
  output logic [31:0] adjustFraction,
  output logic [23:0] adjustCycleCount,
  // pulse generator command push
  output logic [1:0] pegPush,
  output logic [21:0] pegCommand,
  // mean path delay
  output logic mpdStb,
  output logic [28:0] mpdNanos,
  output logic [1:0] mpdFraction,
  // correction adjustments one..three
  output logic [2:0] corrStb,
  output logic [29:0] corrNanos,
  output logic [1:0] corrFraction
);

  // ----------------------------------------
  // register port decode
  // ----------------------------------------
  // staging word address match
  wire logic [4:0] wordHit;
  assign wordHit[0] = regWe && (regAddr == time_engine_pkg::ADDR_WORD1);
  assign wordHit[1] = regWe && (regAddr == time_engine_pkg::ADDR_WORD2);
  assign wordHit[2] = regWe && (regAddr == time_engine_pkg::ADDR_WORD3);
  assign wordHit[3] = regWe && (regAddr == time_engine_pkg::ADDR_WORD4);
  assign wordHit[4] = regWe && (regAddr == time_engine_pkg::ADDR_WORD5);
  wire logic ctrlWe = regWe && (regAddr == time_engine_pkg::ADDR_CTRL);

  // ----------------------------------------
  // control register
  // ----------------------------------------
  logic rdStb_r;        // read strobe, lives one cycle
  logic wrStb_r;        // write strobe, lives one cycle
  logic [2:0] read_select_r;  // read source
  logic [3:0] write_select_r;  // write destination

  wire logic rdStb_nxt = ctrlWe & regWdata[time_engine_pkg::CTRL_RD_BIT];
  wire logic [2:0] read_select_nxt = ctrlWe ? regWdata[time_engine_pkg::CTRL_READ_SELECT_LO +: 3] : read_select_r;
  wire logic wrStb_nxt = ctrlWe & regWdata[time_engine_pkg::CTRL_WR_BIT];
  wire logic [3:0] write_select_nxt = ctrlWe ? regWdata[time_engine_pkg::CTRL_WRITE_SELECT_LO +: 4] : write_select_r;

  // strobes clear after their one execute cycle; a new set always wins
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rdStb_r <= 1'b0;
      wrStb_r <= 1'b0;
      read_select_r <= 3'h0;
      write_select_r <= 4'h0;
    end else begin
      rdStb_r <= rdStb_nxt;
      wrStb_r <= wrStb_nxt;
      read_select_r <= read_select_nxt;
      write_select_r <= write_select_nxt;
    end
  end

  // ----------------------------------------
  // read source mux
  // ----------------------------------------
  read_path_if rp ();

  staging_read_mux u_read_mux (
    .selCode(read_select_r),
    .stamperTwoSourceSelect(stamperTwoSourceSelect),
    .stamperThreeSourceSelect(stamperThreeSourceSelect),
    .curSeconds(curSeconds),
    .curNanos(curNanos),
    .tsSeconds(tsSeconds),
    .tsNanos(tsNanos),
    .tsEdge(tsEdge),
    .tsMsgType(tsMsgType),
    .tsIdentity(tsIdentity),
    .tsSequence(tsSequence),
    .rp(rp.source)
  );

  wire logic readLoad = rdStb_r & rp.loadOk;

  // ----------------------------------------
  // staging words
  // ----------------------------------------
  logic [4:0][15:0] stage_r;  // index 0 is word one

  // hold until software write or read load
  // a read load beats a software write in the same cycle
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      stage_r <= {5{time_engine_pkg::RESET_WORD}};
    end else begin
      for (int i = 0; i < time_engine_pkg::STAGE_N; i++) begin
        if (readLoad) begin
          stage_r[i] <= rp.loadWord[i];
        end else if (wordHit[i]) begin
          stage_r[i] <= regWdata;
        end
      end
    end
  end

  // ----------------------------------------
  // write destination decode
  // ----------------------------------------
  // destination strobes
  wire logic doTime = wrStb_r && (write_select_r == time_engine_pkg::WSEL_TIME);
  wire logic doPeriod = wrStb_r && (write_select_r == time_engine_pkg::WSEL_PERIOD);
  wire logic doAdjust = wrStb_r && (write_select_r == time_engine_pkg::WSEL_ADJUST);
  wire logic [1:0] doPeg = {wrStb_r && (write_select_r == time_engine_pkg::WSEL_PULSE_GENERATOR_TWO),
                            wrStb_r && (write_select_r == time_engine_pkg::WSEL_PULSE_GENERATOR_ONE)};
  wire logic doMpd = wrStb_r && (write_select_r == time_engine_pkg::WSEL_MPD);
  wire logic [2:0] doCorr = {wrStb_r && (write_select_r == time_engine_pkg::WSEL_CORR3),
                             wrStb_r && (write_select_r == time_engine_pkg::WSEL_CORR2),
                             wrStb_r && (write_select_r == time_engine_pkg::WSEL_CORR1)};

  wire logic [47:0] packSeconds = {stage_r[2], stage_r[1], stage_r[0]};
  wire logic [29:0] packTimeNs = {stage_r[4][13:0], stage_r[3]};
  wire logic [31:0] packFrac = {stage_r[4][7:0], stage_r[3], stage_r[2][15:8]};
  wire logic [23:0] packCount = {stage_r[2][7:0], stage_r[1]};
  // command over words four and five
  wire logic [21:0] packCmd = {stage_r[4][5:0], stage_r[3]};
  wire logic [28:0] packMpdNs = {stage_r[4][14:0], stage_r[3][15:2]};
  wire logic [29:0] packCorrNs = {stage_r[4], stage_r[3][15:2]};

  // ----------------------------------------
  // destination registers
  // ----------------------------------------
  // staging still holds pre-read values here
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      timeLoadSeconds <= 48'h0;
      timeLoadNanos <= 30'h0;
      periodNanos <= 8'h00;
      periodFraction <= 32'h0;
      adjustNanos <= 8'h00;
      adjustFraction <= 32'h0;
      adjustCycleCount <= 24'h0;
      pegCommand <= 22'h0;
      mpdNanos <= 29'h0;
      mpdFraction <= 2'h0;
      corrNanos <= 30'h0;
      corrFraction <= 2'h0;
    end else begin
      if (doTime) begin
        timeLoadSeconds <= packSeconds;
        timeLoadNanos <= packTimeNs;
      end
      if (doPeriod) begin
        periodNanos <= stage_r[4][15:8];
        periodFraction <= packFrac;
      end
      if (doAdjust) begin
        adjustNanos <= stage_r[4][15:8];
        adjustFraction <= packFrac;
        adjustCycleCount <= packCount;
      end
      if (|doPeg) begin
        pegCommand <= packCmd;
      end
      if (doMpd) begin
        mpdNanos <= packMpdNs;
        mpdFraction <= stage_r[3][1:0];
      end
      if (|doCorr) begin
        corrNanos <= packCorrNs;
        corrFraction <= stage_r[3][1:0];
      end
    end
  end

  // strobes toward the engine are one-cycle pulses with the data
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      timeLoadStb <= 1'b0;
      periodStb <= 1'b0;
      adjustStb <= 1'b0;
      pegPush <= 2'h0;
      mpdStb <= 1'b0;
      corrStb <= 3'h0;
    end else begin
      timeLoadStb <= doTime;
      periodStb <= doPeriod;
      adjustStb <= doAdjust;
      pegPush <= doPeg;
      mpdStb <= doMpd;
      corrStb <= doCorr;
    end
  end

  // ----------------------------------------
  // fifo pops and header data
  // ----------------------------------------
  // pop the fifo that was read
  wire logic [2:0] popNxt = {readLoad && (read_select_r == time_engine_pkg::RSEL_TS3),
                             readLoad && (read_select_r == time_engine_pkg::RSEL_TS2),
                             readLoad && (read_select_r == time_engine_pkg::RSEL_TS1)};

  // pop follows the capture, so the head entry is never skipped
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tsPop <= 3'h0;
      headerDataOne <= time_engine_pkg::RESET_WORD;
      headerDataTwo <= time_engine_pkg::RESET_WORD;
    end else begin
      tsPop <= popNxt;
      // same entry as the staging load
      if (readLoad && rp.hdrLoad) begin
        headerDataOne <= rp.hdrOne;
        headerDataTwo <= rp.hdrTwo;
      end
    end
  end

  // ----------------------------------------
  // register read back
  // ----------------------------------------
  // reserved control bits read zero
  wire logic [15:0] ctrlView = {rdStb_r, 4'h0, read_select_r, wrStb_r, 3'h0, write_select_r};
  wire logic [15:0] readMux =
    (regAddr == time_engine_pkg::ADDR_WORD1) ? stage_r[0] :
    (regAddr == time_engine_pkg::ADDR_WORD2) ? stage_r[1] :
    (regAddr == time_engine_pkg::ADDR_WORD3) ? stage_r[2] :
    (regAddr == time_engine_pkg::ADDR_WORD4) ? stage_r[3] :
    (regAddr == time_engine_pkg::ADDR_WORD5) ? stage_r[4] :
    (regAddr == time_engine_pkg::ADDR_CTRL) ? ctrlView : 16'h0000;

  // read data is captured on regRe and held until the next one
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      regRdata <= time_engine_pkg::RESET_WORD;
    end else if (regRe) begin
      regRdata <= readMux;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  strobe_clear_a: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (rdStb_r || wrStb_r) && !ctrlWe |=> !rdStb_r && !wrStb_r
  ) else $error("strobe did not clear");

  time_write_a: assert property (
    @(posedge mclk) disable iff (!rst_b)
    doTime |=> timeLoadStb && timeLoadSeconds == $past(packSeconds) &&
               timeLoadNanos == $past(packTimeNs)
  ) else $error("time load mismatch");

  period_pack_a: assert property (
    @(posedge mclk) disable iff (!rst_b)
    doPeriod |=> periodStb && periodNanos == $past(stage_r[4][15:8]) &&
                 periodFraction[7:0] == $past(stage_r[2][15:8])
  ) else $error("period packing wrong");

  peg_push_a: assert property (
    @(posedge mclk) disable iff (!rst_b)
    doPeg[1] |=> pegPush == 2'h2 && pegCommand[21:16] == $past(stage_r[4][5:0])
  ) else $error("pulse command push wrong");

  bad_code_a: assert property (
    @(posedge mclk) disable iff (!rst_b)
    wrStb_r && write_select_r > time_engine_pkg::WSEL_CORR3 |=>
      !timeLoadStb && !periodStb && !adjustStb && pegPush == 2'h0 && !mpdStb && corrStb == 3'h0
  ) else $error("undefined code had an effect");

  read_order_a: assert property (
    @(posedge mclk) disable iff (!rst_b)
    doTime && readLoad |=> timeLoadSeconds == $past(packSeconds) &&
                           stage_r[0] == $past(rp.loadWord[0])
  ) else $error("write did not precede read");

  stage_hold_a: assert property (
    @(posedge mclk) disable iff (!rst_b)
    !readLoad && !wordHit[0] |=> $stable(stage_r[0])
  ) else $error("staging word changed alone");

  header_pop_a: assert property (
    @(posedge mclk) disable iff (!rst_b)
    readLoad && read_select_r == time_engine_pkg::RSEL_TS3 &&
    stamperThreeSourceSelect == time_engine_pkg::SRC_PACKETS |=>
      tsPop == 3'h4 && headerDataTwo == $past(tsSequence[2])
  ) else $error("header not loaded with pop");

  edge_flag_a: assert property (
    @(posedge mclk) disable iff (!rst_b)
    readLoad && read_select_r == time_engine_pkg::RSEL_TS1 |=>
      stage_r[4][time_engine_pkg::EDGE_BIT] == $past(tsEdge[0]) && !stage_r[4][14]
  ) else $error("edge flag wrong");

endmodule : time_engine_indirect_access

`default_nettype wire

// ### verification/mgmt_host_model.sv
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------
// management host on the register port
// ----------------------------------------
module mgmt_host_model (
  // clock
  input wire logic mclk,
  // register port toward the device
  output logic regWe,
  output logic regRe,
  output logic [4:0] regAddr,
  output logic [15:0] regWdata,
  input wire logic [15:0] regRdata
);
  // idle bus starts away from any mapped address
  initial begin
    regWe = 1'b0;
    regRe = 1'b0;
    regAddr = 5'h1F;
    regWdata = 16'hFFFF;
  end

  // one write, entered just after an edge; an idle cycle follows
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    regAddr = a;
    regWdata = d;
    regWe = 1'b1;
    @(posedge mclk);
    #1;
    regWe = 1'b0;
    // released data flips so a stale value never looks valid
    regWdata = ~d;
    @(posedge mclk);
    #1;
  endtask : wr

  // one read; data is taken after the edge that took the request
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    regAddr = a;
    regRe = 1'b1;
    @(posedge mclk);
    #1;
    regRe = 1'b0;
    regAddr = ~a;
    d = regRdata;
    @(posedge mclk);
    #1;
  endtask : rd
endmodule : mgmt_host_model

`default_nettype wire

// ### verification/tb.sv
`timescale 1ns/10ps
`default_nettype none

module tb;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic mclk, rst_b, regWe, regRe, timeLoadStb, periodStb, adjustStb, mpdStb;
  logic [4:0] regAddr;
  logic [15:0] regWdata, regRdata, headerDataOne, headerDataTwo, rv;
  logic [2:0] stamperTwoSourceSelect, stamperThreeSourceSelect, tsEdge, tsPop, corrStb;
  logic [47:0] curSeconds, timeLoadSeconds;
  logic [29:0] curNanos, timeLoadNanos, corrNanos;
  logic [2:0][47:0] tsSeconds;
  logic [2:0][29:0] tsNanos;
  logic [2:0][3:0] tsMsgType;
  logic [2:0][11:0] tsIdentity;
  logic [2:0][15:0] tsSequence;
  logic [7:0] periodNanos, adjustNanos;
  logic [31:0] periodFraction, adjustFraction;
  logic [23:0] adjustCycleCount;
  logic [1:0] pegPush, mpdFraction, corrFraction;
  logic [21:0] pegCommand;
  logic [28:0] mpdNanos;
  logic [4:0][15:0] w, v;
  int failures, checks_done;
  // every destination pulse in one vector, time load at bit 0
  wire logic [8:0] stbVec = {corrStb, mpdStb, pegPush, adjustStb, periodStb, timeLoadStb};
  localparam logic [4:0] CTRL = time_engine_pkg::ADDR_CTRL;

  time_engine_indirect_access i_time_engine_indirect_access (
    .mclk, .rst_b, .regWe, .regRe, .regAddr, .regWdata, .regRdata,
    .stamperTwoSourceSelect, .stamperThreeSourceSelect, .curSeconds, .curNanos,
    .tsSeconds, .tsNanos, .tsEdge, .tsMsgType, .tsIdentity, .tsSequence, .tsPop,
    .headerDataOne, .headerDataTwo, .timeLoadStb, .timeLoadSeconds, .timeLoadNanos,
    .periodStb, .periodNanos, .periodFraction, .adjustStb, .adjustNanos,
    .adjustFraction, .adjustCycleCount, .pegPush, .pegCommand, .mpdStb, .mpdNanos,
    .mpdFraction, .corrStb, .corrNanos, .corrFraction
  );
  mgmt_host_model i_mgmt_host_model (.mclk, .regWe, .regRe, .regAddr, .regWdata, .regRdata);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // wide enough for all five staging words at once
  task automatic chk(input string what, input logic [79:0] seen, input logic [79:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task automatic put5(input logic [4:0][15:0] d);
    for (int i = 0; i < 5; i++) begin
      i_mgmt_host_model.wr(time_engine_pkg::ADDR_WORD1 + 5'(i), d[i]);
    end
  endtask : put5

  task automatic get5(output logic [4:0][15:0] d);
    for (int i = 0; i < 5; i++) begin
      i_mgmt_host_model.rd(time_engine_pkg::ADDR_WORD1 + 5'(i), d[i]);
    end
  endtask : get5

  // expected destination pulse for a write-select code
  function automatic logic [8:0] stb_for(input logic [3:0] c);
    case (c)
      4'h0, 4'h1, 4'h2, 4'h3, 4'h4: stb_for = 9'h001 << c;
      4'h8, 4'h9, 4'hA, 4'hB: stb_for = 9'h001 << (c - 4'h3);
      default: stb_for = 9'h000;
    endcase
  endfunction : stb_for

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // reset values of all six registers, unmapped read gives zero
  task automatic t_reset;
    for (int i = 0; i < 7; i++) begin
      i_mgmt_host_model.rd(time_engine_pkg::ADDR_WORD1 + 5'(i), rv);
      chk("reset value", rv, 64'h0);
    end
  endtask : t_reset

  // staging read-back, reserved control bits, ignored unmapped write
  task automatic t_regs;
    w = {16'h5A5A, 16'hA5A5, 16'h0FF0, 16'hF00F, 16'h1234};
    put5(w);
    i_mgmt_host_model.wr(CTRL, 16'h7F7F);
    i_mgmt_host_model.wr(5'h10, 16'hDEAD);
    get5(v);
    chk("staging", v, w);
    i_mgmt_host_model.rd(CTRL, rv);
    chk("ctrl readback", rv, 16'h070F);
  endtask : t_regs

  // time write and self-clearing write strobe
  task automatic t_time_write;
    w = {16'h2555, 16'h4444, 16'h3333, 16'h2222, 16'h1111};
    put5(w);
    i_mgmt_host_model.wr(CTRL, 16'h0080);
    chk("time stb", stbVec, 9'h001);
    chk("time sec", timeLoadSeconds, 48'h333322221111);
    chk("time ns", timeLoadNanos, {w[4][13:0], w[3]});
    i_mgmt_host_model.rd(CTRL, rv);
    chk("wr clears", rv, 16'h0000);
    chk("one pulse", stbVec, 9'h000);
  endtask : t_time_write

  // every write-select code, then the held layouts
  task automatic t_codes;
    w = {16'hDEF1, 16'h9ABC, 16'h5678, 16'h1234, 16'h0F0F};
    put5(w);
    for (int c = 0; c < 16; c++) begin
      i_mgmt_host_model.wr(CTRL, 16'h0080 | 16'(c));
      chk("code stb", stbVec, stb_for(4'(c)));
    end
    chk("per", {periodNanos, periodFraction}, {w[4], w[3], w[2][15:8]});
    chk("adj", {adjustNanos, adjustFraction}, {w[4], w[3], w[2][15:8]});
    chk("adjust_cycle_count", adjustCycleCount, {w[2][7:0], w[1]});
    chk("peg", pegCommand, {w[4][5:0], w[3]});
    chk("mpd", {mpdNanos, mpdFraction}, {w[4][14:0], w[3]});
    chk("corr", {corrNanos, corrFraction}, {w[4], w[3]});
    get5(v);
    chk("staging kept", v, w);
  endtask : t_codes

  // current time read layout
  task automatic t_time_read;
    curSeconds = 48'hA1A2B3B4C5C6;
    curNanos = 30'h2BCD1234;
    i_mgmt_host_model.wr(CTRL, 16'h8000);
    chk("no pop", tsPop, 3'b000);
    get5(v);
    chk("time rd", v, {2'b00, curNanos, curSeconds});
  endtask : t_time_read

  // fifo pop with header update only for packet-stamping fifos
  task automatic t_fifo(input int k, input logic [2:0] src, input logic edgeV);
    logic [31:0] hdrOld;
    logic upd;
    tsSeconds[k] = {16'hC000 + 16'(k), 16'hB000, 16'hA000};
    tsNanos[k] = {14'h1555, 16'h7000 + 16'(k)};
    tsEdge[k] = edgeV;
    tsMsgType[k] = 4'hD - 4'(k);
    tsIdentity[k] = 12'h9A0 + 12'(k);
    tsSequence[k] = 16'h4321 + 16'(k);
    stamperTwoSourceSelect = src;
    stamperThreeSourceSelect = src;
    hdrOld = {headerDataTwo, headerDataOne};
    upd = (k != 0) && (src == 3'h0);
    i_mgmt_host_model.wr(CTRL, 16'h8000 | {5'h00, 3'(k + 1), 8'h00});
    chk("pop", tsPop, 3'b001 << k);
    chk("hdr", {headerDataTwo, headerDataOne},
        upd ? {tsSequence[k], tsMsgType[k], tsIdentity[k]} : hdrOld);
    get5(v);
    chk("fifo sec", {v[2], v[1], v[0]}, tsSeconds[k]);
    chk("fifo ns", {v[4], v[3]}, {edgeV, 1'b0, tsNanos[k]});
  endtask : t_fifo

  // both strobes: old staging goes out before the read loads
  task automatic t_both;
    w = {16'h1357, 16'hCDEF, 16'h89AB, 16'h4567, 16'h0123};
    put5(w);
    curSeconds = 48'h0F0E0D0C0B0A;
    curNanos = 30'h1F2E3D4C;
    i_mgmt_host_model.wr(CTRL, 16'h8080);
    chk("both wr", timeLoadSeconds, {w[2], w[1], w[0]});
    get5(v);
    chk("both rd", v, {2'b00, curNanos, curSeconds});
  endtask : t_both

  // undefined read and write codes change nothing
  task automatic t_undef;
    get5(w);
    i_mgmt_host_model.wr(CTRL, 16'h858F);
    chk("undef stb", {stbVec, tsPop}, 12'h000);
    get5(v);
    chk("undef staging", v, w);
    i_mgmt_host_model.rd(CTRL, rv);
    chk("undef ctrl", rv, 16'h050F);
  endtask : t_undef

  // ----------------------------------------
  // clock, watchdog and main sequence
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // the whole run needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    tally_and_finish();
  end

  initial begin
    failures = 0;
    checks_done = 0;
    rst_b = 1'b0;
    stamperTwoSourceSelect = 3'h0;
    stamperThreeSourceSelect = 3'h0;
    curSeconds = '0;
    curNanos = '0;
    tsSeconds = '0;
    tsNanos = '0;
    tsEdge = '0;
    tsMsgType = '0;
    tsIdentity = '0;
    tsSequence = '0;
    repeat (12) @(posedge mclk);
    #1;
    rst_b = 1'b1;
    @(posedge mclk);
    #1;
    t_reset();
    t_regs();
    t_time_write();
    t_codes();
    t_time_read();
    t_fifo(0, 3'h0, 1'b1);
    t_fifo(1, 3'h0, 1'b0);
    t_fifo(1, 3'h1, 1'b1);
    t_fifo(2, 3'h0, 1'b0);
    t_fifo(2, 3'h2, 1'b0);
    t_both();
    t_undef();
    tally_and_finish();
  end
endmodule : tb

`default_nettype wire
